// >>> acc_consts.vh
// Constants for the converter control block: addresses, bit positions, timing counts.
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_ADDR_CONTROL      8'hc4
`define ACC_ADDR_RESULT       8'hc5
`define ACC_BIT_CHAN_LO       0
`define ACC_BIT_CHAN_HI       1
`define ACC_BIT_TIME_SEL      2
`define ACC_BIT_START_BUSY    3
`define ACC_BIT_DONE          4
`define ACC_BIT_EXT_EN        5
`define ACC_BIT_REF_OFF       6
`define ACC_CTRL_RESET        8'h00
`define ACC_RESULT_RESET      8'h00
`define ACC_CYC_SHORT         6'd24
`define ACC_CYC_LONG          6'd48
`define ACC_CYC_SAMPLE        6'd6
`define ACC_MC_DIV            4'd12
`define ACC_ST_IDLE           2'b00
`define ACC_ST_SAMPLE         2'b01
`define ACC_ST_CONVERT        2'b10
`define ACC_ST_FINISH         2'b11
`endif

// >>> acc_converter_control.v
// Conversion control logic with special-function register access.
`timescale 1ns/10ps
`include "acc_consts.vh"

module acc_converter_control #(
  parameter MC_DIV = `ACC_MC_DIV
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  input  wire       external_start_pin,
  input  wire       power_down,
  input  wire       idle_mode,
  input  wire [7:0] conv_data,
  output reg  [1:0] mux_select,
  output reg        sample_hold,
  output reg        convert_active,
  output reg        reference_off,
  output reg        done_irq,
  output reg        busy
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [1:0] chan_reg;
  reg       time_sel_reg;
  reg       start_busy_reg;
  reg       done_reg;
  reg       ext_en_reg;
  reg       ref_off_reg;
  reg [7:0] result_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [5:0] mc_count_reg;
  reg [3:0] div_count_reg;
  reg       pin_sync1_reg;
  reg       pin_sync2_reg;
  reg       pin_prev_reg;
  reg       pd_prev_reg;

  // The reset image of the control register is kept whole, so the time-select field's reset value
  // is taken from it by bit position rather than by a shift that would drop bits silently.
  localparam [7:0] CTRL_RESET_IMAGE = `ACC_CTRL_RESET;

  // ****************************************************************
  // Decode and timing
  // ****************************************************************
  // The machine cycle tick keeps running in idle so conversions finish there.
  wire mc_tick = (div_count_reg == MC_DIV - 4'd1);
  wire wr_ctrl = sfr_wr && (sfr_addr == `ACC_ADDR_CONTROL);
  wire pin_fall = pin_prev_reg && !pin_sync2_reg;
  wire pd_entry = power_down && !pd_prev_reg;
  wire sw_start = wr_ctrl && sfr_wdata[`ACC_BIT_START_BUSY];
  wire ext_start = pin_fall && ext_en_reg;
  // A blocked start is dropped outright; nothing latches it for later.
  wire start_ok = (sw_start || ext_start) && !start_busy_reg && !done_reg &&
                  !power_down;
  wire [5:0] conv_len = time_sel_reg ? `ACC_CYC_LONG : `ACC_CYC_SHORT;
  wire last_cycle = mc_tick && (mc_count_reg == conv_len - 6'd1);

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ACC_ST_IDLE: begin
        if (start_ok) begin
          state_next = `ACC_ST_SAMPLE;
        end
      end
      `ACC_ST_SAMPLE: begin
        if (mc_tick && mc_count_reg == `ACC_CYC_SAMPLE - 6'd1) begin
          state_next = `ACC_ST_CONVERT;
        end
      end
      `ACC_ST_CONVERT: begin
        if (last_cycle) begin
          state_next = `ACC_ST_FINISH;
        end
      end
      `ACC_ST_FINISH: begin
        if (mc_tick) begin
          state_next = `ACC_ST_IDLE;
        end
      end
      default: begin
        state_next = `ACC_ST_IDLE;
      end
    endcase
    if (pd_entry && state_reg != `ACC_ST_FINISH) begin
      state_next = `ACC_ST_IDLE;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg      <= `ACC_ST_IDLE;
      mc_count_reg   <= 6'd0;
      div_count_reg  <= 4'd0;
      pin_sync1_reg  <= 1'b1;
      pin_sync2_reg  <= 1'b1;
      pin_prev_reg   <= 1'b1;
      pd_prev_reg    <= 1'b0;
      chan_reg       <= 2'b00;
      time_sel_reg   <= CTRL_RESET_IMAGE[`ACC_BIT_TIME_SEL];
      start_busy_reg <= 1'b0;
      done_reg       <= 1'b0;
      ext_en_reg     <= 1'b0;
      ref_off_reg    <= 1'b0;
      result_reg     <= `ACC_RESULT_RESET;
      sfr_rdata      <= 8'h00;
      mux_select     <= 2'b00;
      sample_hold    <= 1'b0;
      convert_active <= 1'b0;
      reference_off  <= 1'b0;
      done_irq       <= 1'b0;
      busy           <= 1'b0;
    end else if (clk_en) begin
      pin_sync1_reg <= external_start_pin;
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg  <= pin_sync2_reg;
      pd_prev_reg   <= power_down;
      state_reg     <= state_next;
      if (mc_tick || start_ok) begin
        div_count_reg <= 4'd0;
      end else begin
        div_count_reg <= div_count_reg + 4'd1;
      end
      if (start_ok || state_next == `ACC_ST_IDLE) begin
        mc_count_reg <= 6'd0;
      end else if (mc_tick) begin
        mc_count_reg <= mc_count_reg + 6'd1;
      end

      // Software writes of the plain control bits.
      if (wr_ctrl) begin
        time_sel_reg <= sfr_wdata[`ACC_BIT_TIME_SEL];
        ext_en_reg   <= sfr_wdata[`ACC_BIT_EXT_EN];
        ref_off_reg  <= sfr_wdata[`ACC_BIT_REF_OFF];
        if (!done_reg && !start_busy_reg) begin
          chan_reg <= sfr_wdata[`ACC_BIT_CHAN_HI:`ACC_BIT_CHAN_LO];
        end
      end

      // Busy: set by a start, cleared only by hardware at the end or on abort.
      if (start_ok) begin
        start_busy_reg <= 1'b1;
      end else if ((state_reg == `ACC_ST_FINISH && mc_tick) || pd_entry) begin
        start_busy_reg <= 1'b0;
      end

      // Done: hardware set wins over a software clear in the same cycle.
      if (state_reg == `ACC_ST_CONVERT && last_cycle &&
          !(pd_entry)) begin
        done_reg   <= 1'b1;
        result_reg <= conv_data;
      end else if (wr_ctrl && !sfr_wdata[`ACC_BIT_DONE]) begin
        done_reg <= 1'b0;
      end
      // Power-down leaves done and result untouched.

      if (sfr_rd && sfr_addr == `ACC_ADDR_CONTROL) begin
        sfr_rdata <= {1'b0, ref_off_reg, ext_en_reg, done_reg, start_busy_reg,
                      time_sel_reg, chan_reg};
      end else if (sfr_rd && sfr_addr == `ACC_ADDR_RESULT) begin
        sfr_rdata <= result_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
      mux_select     <= chan_reg;
      sample_hold    <= (state_next == `ACC_ST_SAMPLE);
      convert_active <= (state_next == `ACC_ST_CONVERT);
      reference_off  <= ref_off_reg;
      done_irq       <= done_reg;
      busy           <= start_busy_reg;
    end
  end

endmodule // acc_converter_control

// >>> acc_cc_sva.sv
// Port-level timing checks for the converter control block.
`timescale 1ns/10ps
module acc_cc_sva #(parameter MC_DIV = 12) (
  input wire       clk, rst_n, sfr_wr, power_down, sample_hold,
  input wire       reference_off, done_irq, busy,
  input wire [7:0] sfr_addr, sfr_wdata,
  input wire [1:0] mux_select
);
  // ****************
  // Checks
  // ****************
  localparam int OV = MC_DIV;
  logic [7:0] slen;
  wire wr_ctl = sfr_wr && sfr_addr == 8'hc4;
  always @(posedge clk) slen <= sample_hold ? slen + 8'h01 : 8'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  busy_hold_a: assert property (disable iff (!rst_n || power_down)
    $rose(busy) |=> busy[*8]) else $error("busy dropped early");
  overlap_a: assert property (busy && done_irq |-> ##[1:OV] !busy)
    else $error("done and busy overlap too long");
  sample_len_a: assert property (disable iff (!rst_n || power_down)
    $fell(sample_hold) |-> slen == 8'(6 * MC_DIV)) else $error("sampling length wrong");
  sample_start_a: assert property ($rose(busy) |-> sample_hold)
    else $error("conversion without sampling");
  ref_off_a: assert property (wr_ctl |-> ##2 reference_off == $past(sfr_wdata[6], 2))
    else $error("reference power bit not applied");
  abort_pd_a: assert property ($rose(power_down) && busy |-> ##[1:6] !busy)
    else $error("conversion not aborted");
  pd_keep_a: assert property ($rose(power_down) && done_irq |=> done_irq[*4])
    else $error("done lost on power-down");
  chan_hold_a: assert property (busy && $past(busy, 2) && wr_ctl |=> $stable(mux_select)[*2])
    else $error("channel changed while busy");
  cover property ($fell(busy));
  cover property ($rose(power_down) && busy);
  cover property (busy && done_irq);
endmodule // acc_cc_sva

// >>> acc_analog_model.sv
// Behavioural analog front end answering the converter.
`timescale 1ns/10ps
module acc_analog_model (
  input  wire        clk,
  input  wire        busy,
  input  wire [1:0]  mux_select,
  input  wire [31:0] levels,
  output logic [7:0] conv_data
);
  // ****************
  // Converter value
  // ****************
  // Outside a conversion the value toggles, so a stale capture cannot pass.
  initial conv_data = 8'h5a;
  always @(posedge clk) conv_data <= busy ? levels[{mux_select, 3'b000} +: 8] : ~conv_data;
endmodule // acc_analog_model

// >>> test_adc_conversion_control.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module test_adc_conversion_control;
  // ****************
  // Bench
  // ****************
  localparam int MC = 2;
  logic        clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, pin = 1, pd = 0, idle = 0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, cd;
  logic [1:0]  mux;
  logic        sh, ca, ro, done_irq, busy, rd_d = 0, bprev = 0;
  logic [31:0] lv = 32'h0;
  logic [7:0]  q[$];
  int          errors = 0, tests_run = 0, bl = 0;
  acc_converter_control #(.MC_DIV(MC)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .sfr_addr(addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .external_start_pin(pin), .power_down(pd), .idle_mode(idle), .conv_data(cd),
    .mux_select(mux), .sample_hold(sh), .convert_active(ca), .reference_off(ro),
    .done_irq(done_irq), .busy(busy));
  acc_analog_model u_model (.clk(clk), .busy(busy), .mux_select(mux), .levels(lv),
    .conv_data(cd));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (rd_d) chk("rdata", q.pop_front(), rdata);
    rd_d <= sfr_rd;
    bl <= busy ? (bprev ? bl + 1 : 1) : bl;
    bprev <= busy;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    sfr_wr <= 1;
    @(posedge clk);
    sfr_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    sfr_rd <= 1;
    q.push_back(e);
    @(posedge clk);
    sfr_rd <= 0;
  endtask
  task automatic wt(input logic dn);
    int n;
    n = 0;
    while (!(busy === ~dn && done_irq === dn) && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) chk("wait", 8'h01, 8'h00);
  endtask
  task automatic pulse();
    @(posedge clk);
    pin <= 0;
    repeat (4) @(posedge clk);
    pin <= 1;
  endtask
  task automatic conv(input logic [7:0] c);
    logic [7:0] r;
    wr(8'hc4, c);
    wt(0);
    wr(8'hc4, c ^ 8'h03);
    wt(1);
    chk("length", 8'((c[2] ? 49 : 25) * MC), 8'(bl));
    r = lv[{c[1:0], 3'b000} +: 8];
    rd(8'hc4, {1'b0, c[6:5], 2'b10, c[2:0]});
    lv <= ~lv;
    rd(8'hc5, r);
    wr(8'hc4, c | 8'h18);
    rd(8'hc5, r);
    wr(8'hc4, c & 8'h67);
    rd(8'hc4, c & 8'h67);
  endtask
  initial begin
    void'($urandom(95));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rd(8'hc4, 8'h00);
    rd(8'hc5, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lv <= $urandom;
      conv({1'b0, 1'($urandom), 3'b001, i[0], i[1:0]});
    end
    idle <= 1;
    wr(8'hc4, 8'h20);
    pulse();
    wt(1);
    rd(8'hc4, 8'h30);
    wr(8'hc4, 8'h00);
    idle <= 0;
    wr(8'hc4, 8'h10);
    pulse();
    repeat (8) @(posedge clk);
    rd(8'hc4, 8'h00);
    wr(8'hc4, 8'h08);
    repeat (10) @(posedge clk);
    pd <= 1;
    repeat (6) @(posedge clk);
    rd(8'hc4, 8'h00);
    pd <= 0;
    wr(8'hc4, 8'h08);
    wt(1);
    pd <= 1;
    rd(8'hc4, 8'h10);
    print_verdict();
  end
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
endmodule // test_adc_conversion_control
bind acc_converter_control acc_cc_sva #(.MC_DIV(MC_DIV)) u_sva (.clk(clk), .rst_n(rst_n),
  .sfr_wr(sfr_wr), .power_down(power_down), .sample_hold(sample_hold),
  .reference_off(reference_off), .done_irq(done_irq), .busy(busy), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .mux_select(mux_select));
